// >>> design/sac_adc_ctrl.sv
// Control logic of a 12-bit successive-approximation converter, with
// its register file on an Avalon-MM slave with waitrequest.
// Assumes the analog core answers comp_hi on the same clock, high when
// the input is at or above the trial code, and that timer match, stop
// mode and interrupt acknowledge come from logic on sys_clk.
`include "sac_regs.svh"
module sac_adc_ctrl #(
    parameter int NUM_TIMERS = `SAC_NUM_TIMERS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input sac_pkg::sac_av_req_t av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    input wire logic comp_hi,
    input wire logic [NUM_TIMERS-1:0] timer_match,
    input wire logic stop_mode,
    input wire logic int_ack,
    output sac_pkg::sac_afe_t afe,
    output logic irq
);
    sac_pkg::sac_st_t q, d;
    logic tick, start, active, wr, done_w, drop_w;
    logic [7:0] wd;
    logic [11:0] sar_n;

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] idx);
        return (a[15:2] == idx[13:0]) && (a[1:0] == 2'h0);
    endfunction : hit

    function automatic logic [7:0] read_mux(input sac_pkg::sac_st_t s,
                                            input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (hit(a, `SAC_IDX_CTRL_LO)) begin
            // Start bit always reads back as zero
            v = {s.en, 1'b0, s.ref_ext, s.conversion_complete_flag, s.chan};
        end else if (hit(a, `SAC_IDX_CTRL_HI)) begin
            v = {s.irqf, 1'b0, s.trig_sel, s.align, s.clk_div};
        end else if (hit(a, `SAC_IDX_RES_LO)) begin
            v = s.align ? s.res[7:0] : {s.res[3:0], 4'h0};
        end else if (hit(a, `SAC_IDX_RES_HI)) begin
            v = s.align ? {4'h0, s.res[11:8]} : s.res[11:4];
        end else if (hit(a, `SAC_IDX_STATUS)) begin
            v = {6'h00, s.sts};
        end else if (hit(a, `SAC_IDX_MASK)) begin
            v = {6'h00, s.msk};
        end
        return v;
    endfunction : read_mux

    sac_clkdiv u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(q.state != sac_pkg::SAC_IDLE),
        .div_sel(q.clk_div),
        .tick(tick)
    );

    sac_trig #(
        .NUM_TIMERS(NUM_TIMERS)
    ) u_trig (
        .sys_clk(sys_clk),
        .rst(rst),
        .sel(q.trig_sel),
        .sw_go(q.sw_go),
        .timer_match(timer_match),
        .start(start)
    );

    assign active = q.en && !stop_mode;
    assign wd = av_req.writedata[7:0];
    // Writes take effect only on the edge that ends the wait
    assign wr = av_req.write && !q.waitreq && av_req.byteenable[0];

    always_comb begin
        d = q;
        d.sw_go = 1'b0;
        done_w = 1'b0;
        drop_w = 1'b0;
        sar_n = q.sar;
        // One wait cycle, then a single answer cycle
        if ((av_req.read || av_req.write) && q.waitreq) begin
            d.waitreq = 1'b0;
            d.rdata = read_mux(q, av_req.address);
        end else begin
            d.waitreq = 1'b1;
        end
        if (wr && hit(av_req.address, `SAC_IDX_CTRL_LO)) begin
            d.en = wd[`SAC_CL_ENABLE];
            // start pulse on write of one
            d.sw_go = wd[`SAC_CL_START];
            d.ref_ext = wd[`SAC_CL_REF];
            d.chan = wd[`SAC_CL_CHAN];
            if (!wd[`SAC_CL_ENABLE]) begin
                d.conversion_complete_flag = 1'b0;
            end
        end
        if (wr && hit(av_req.address, `SAC_IDX_CTRL_HI)) begin
            if (!wd[`SAC_CH_IRQ]) begin
                d.irqf = 1'b0;
            end
            d.trig_sel = wd[`SAC_CH_TRIG];
            d.align = wd[`SAC_CH_ALIGN];
            d.clk_div = wd[`SAC_CH_DIV];
        end
        if (wr && hit(av_req.address, `SAC_IDX_STATUS)) begin
            d.sts = q.sts & ~wd[`SAC_EV_BITS];
        end
        if (wr && hit(av_req.address, `SAC_IDX_MASK)) begin
            d.msk = wd[`SAC_EV_BITS];
        end
        if (int_ack) begin
            d.irqf = 1'b0;
        end
        if (stop_mode) begin
            d.conversion_complete_flag = 1'b0;
        end
        unique case (q.state)
            sac_pkg::SAC_IDLE: begin
                if (start && active) begin
                    d.state = sac_pkg::SAC_SETUP;
                    d.tcnt = 6'h00;
                    d.conversion_complete_flag = 1'b0;
                    d.afe.chan = q.chan;
                    d.afe.core_supply = (q.chan == `SAC_CHAN_CORE);
                end else if (start) begin
                    drop_w = 1'b1;
                end
            end
            sac_pkg::SAC_SETUP: begin
                drop_w = start;
                if (!active) begin
                    d.state = sac_pkg::SAC_IDLE;
                end else if (tick) begin
                    d.tcnt = q.tcnt + 6'h01;
                    if (q.tcnt == `SAC_SETUP_LAST) begin
                        d.state = sac_pkg::SAC_CONV;
                        d.sar = `SAC_SAR_FIRST;
                        d.bidx = `SAC_MSB_IDX;
                        d.phase = 2'h0;
                    end
                end
            end
            sac_pkg::SAC_CONV: begin
                drop_w = start;
                if (!active) begin
                    d.state = sac_pkg::SAC_IDLE;
                end else if (tick) begin
                    d.tcnt = q.tcnt + 6'h01;
                    d.phase = q.phase + 2'h1;
                    if (q.phase == `SAC_PHASE_LAST) begin
                        // keep or drop the trial bit
                        sar_n[q.bidx] = comp_hi;
                        if (q.bidx == 4'h0) begin
                            done_w = 1'b1;
                            d.res = sar_n;
                            d.state = sac_pkg::SAC_IDLE;
                        end else begin
                            sar_n[q.bidx - 4'h1] = 1'b1;
                            d.bidx = q.bidx - 4'h1;
                        end
                        d.sar = sar_n;
                    end
                end
            end
            default: begin
                d.state = sac_pkg::SAC_IDLE;
            end
        endcase
        if (done_w) begin
            d.conversion_complete_flag = 1'b1;
            d.irqf = 1'b1;
            d.sts[`SAC_EV_DONE] = 1'b1;
        end
        if (drop_w) begin
            d.sts[`SAC_EV_DROP] = 1'b1;
        end
        d.irq = |(d.sts & d.msk);
        d.afe.powered = d.en && !stop_mode;
        d.afe.sample = (d.state == sac_pkg::SAC_SETUP);
        d.afe.trial = d.sar;
        d.afe.ref_ext = d.ref_ext;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.waitreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign av_readdata = {24'h000000, q.rdata};
    assign av_waitrequest = q.waitreq;
    assign afe = q.afe;
    assign irq = q.irq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_DONE_SETS: assert property (
        done_w |=> q.conversion_complete_flag && q.irqf && q.sts[`SAC_EV_DONE]
            && q.state == sac_pkg::SAC_IDLE)
        else $error("completion did not set flags");

    AST_BUSY_FLAG: assert property (
        q.state != sac_pkg::SAC_IDLE |-> !q.conversion_complete_flag)
        else $error("complete flag high while converting");

    AST_CONV_LEN: assert property (
        done_w |-> q.tcnt == `SAC_CONV_LAST && q.bidx == 4'h0)
        else $error("conversion length is not 58 ticks");

    AST_ALIGN_LO: assert property (
        av_req.read && q.waitreq && !q.align
            && hit(av_req.address, `SAC_IDX_RES_LO)
            |=> q.rdata[3:0] == 4'h0 && q.rdata[7:4] == $past(q.res[3:0]))
        else $error("left aligned low byte wrong");

    AST_IRQ_W1: assert property (
        wr && hit(av_req.address, `SAC_IDX_CTRL_HI) && wd[`SAC_CH_IRQ]
            && !q.irqf && !done_w |=> !q.irqf)
        else $error("writing one changed interrupt flag");

    AST_STOP: assert property (
        stop_mode |=> q.state == sac_pkg::SAC_IDLE && !q.afe.powered
            && !q.conversion_complete_flag)
        else $error("converter active in stop mode");

    AST_IGNORE: assert property (
        start && q.state != sac_pkg::SAC_IDLE |=> q.tcnt >= $past(q.tcnt)
            && q.sts[`SAC_EV_DROP])
        else $error("trigger restarted a busy conversion");

    AST_CHAN: assert property (
        start && active && q.state == sac_pkg::SAC_IDLE
            |=> q.afe.chan == $past(q.chan)
            && q.afe.core_supply == ($past(q.chan) == `SAC_CHAN_CORE))
        else $error("channel not routed at start");

    AST_SW_START: assert property (
        wr && hit(av_req.address, `SAC_IDX_CTRL_LO) && wd[`SAC_CL_START]
            && wd[`SAC_CL_ENABLE] && q.trig_sel == `SAC_TRIG_SW
            && q.state == sac_pkg::SAC_IDLE && !stop_mode
            |=> ##1 q.state == sac_pkg::SAC_SETUP || stop_mode)
        else $error("software start did not begin conversion");

    AST_BUS_ACK: assert property (
        (av_req.read || av_req.write) && q.waitreq |=> !q.waitreq ##1 q.waitreq)
        else $error("bus answer not one cycle after request");

    COV_DONE: cover property (done_w);
    COV_DROP: cover property (start && q.state == sac_pkg::SAC_CONV);
    COV_TIMER: cover property (start && q.trig_sel != `SAC_TRIG_SW);
    COV_ABORT: cover property (q.state == sac_pkg::SAC_CONV && stop_mode);
endmodule : sac_adc_ctrl

// >>> design/sac_clkdiv.sv
// Converter clock divider: one-cycle tick every 1, 2, 4 or 8 cycles.
// Assumes run stays high for a whole conversion.
`include "sac_regs.svh"
module sac_clkdiv (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] div_sel,
    output logic tick
);
    sac_pkg::sac_div_t q, d;
    logic [2:0] lim;

    always_comb begin
        lim = 3'(({1'b0, 2'b00} + 3'h1) << div_sel) - 3'h1;
        d = q;
        // Restart on idle so the first tick lands a full period later
        if (!run) begin
            d.cnt = 3'h0;
            d.tick = 1'b0;
        end else if (q.cnt >= lim) begin
            d.cnt = 3'h0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 3'h1;
            d.tick = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : sac_clkdiv

// >>> design/sac_pkg.sv
// Types shared by the converter control block and its helpers.
// Assumes sac_regs.svh is on the include path.
`include "sac_regs.svh"
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_SETUP = 2'b01,
        SAC_CONV = 2'b10
    } sac_state_t;

    typedef struct packed {
        logic [15:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } sac_av_req_t;

    // Toward the analog core and input multiplexer
    typedef struct packed {
        logic powered;
        logic sample;
        logic [11:0] trial;
        logic [3:0] chan;
        logic core_supply;
        logic ref_ext;
    } sac_afe_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } sac_div_t;

    typedef struct packed {
        sac_state_t state;
        logic en;
        logic sw_go;
        logic ref_ext;
        logic conversion_complete_flag;
        logic [3:0] chan;
        logic irqf;
        logic [2:0] trig_sel;
        logic align;
        logic [1:0] clk_div;
        logic [11:0] res;
        logic [11:0] sar;
        logic [5:0] tcnt;
        logic [3:0] bidx;
        logic [1:0] phase;
        logic [1:0] sts;
        logic [1:0] msk;
        logic irq;
        logic waitreq;
        logic [7:0] rdata;
        sac_afe_t afe;
    } sac_st_t;

endpackage : sac_pkg

// >>> design/sac_regs.svh
// Register indices, field positions, reset values and timing counts
// for the converter control block. Definitions only.
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define SAC_IDX_CTRL_LO 16'h1050
`define SAC_IDX_CTRL_HI 16'h1051
`define SAC_IDX_RES_LO 16'h1052
`define SAC_IDX_RES_HI 16'h1053
`define SAC_IDX_STATUS 16'h1054
`define SAC_IDX_MASK 16'h1055

// converter_control_low fields
`define SAC_CL_ENABLE 7
`define SAC_CL_START 6
`define SAC_CL_REF 5
`define SAC_CL_FLAG 4
`define SAC_CL_CHAN 3:0
// converter_control_high fields
`define SAC_CH_IRQ 7
`define SAC_CH_TRIG 5:3
`define SAC_CH_ALIGN 2
`define SAC_CH_DIV 1:0
// Status and mask fields
`define SAC_EV_DONE 0
`define SAC_EV_DROP 1
`define SAC_EV_BITS 1:0

// Reset values
`define SAC_CTRL_RST 8'h00
`define SAC_EV_RST 2'h0
`define SAC_RES_RST 12'h000

// Codes
`define SAC_CHAN_CORE 4'hF
`define SAC_TRIG_SW 3'h0
`define SAC_NUM_TIMERS 6

// Conversion timing, in converter clock ticks; the last two in nanoseconds
`define SAC_SETUP_LAST 6'h09
`define SAC_CONV_LAST 6'h39
`define SAC_PHASE_LAST 2'h3
`define SAC_MSB_IDX 4'hB
`define SAC_SAR_FIRST 12'h800
`define SAC_MIN_CONV_NS 20000
`define SAC_CLK_NS 100

`endif

// >>> design/sac_trig.sv
// Start trigger selection: software start pulse or a timer match edge.
// Timer match signals come from logic on the same clock.
`include "sac_regs.svh"
module sac_trig #(
    parameter int NUM_TIMERS = `SAC_NUM_TIMERS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [2:0] sel,
    input wire logic sw_go,
    input wire logic [NUM_TIMERS-1:0] timer_match,
    output logic start
);
    logic [NUM_TIMERS-1:0] prev_q, prev_d, edge_w;

    generate
        if (NUM_TIMERS < 1 || NUM_TIMERS > `SAC_NUM_TIMERS) begin : g_chk
            $error("NUM_TIMERS must be 1 to 6");
        end
    endgenerate

    assign edge_w = timer_match & ~prev_q;

    always_comb begin
        prev_d = timer_match;
        start = 1'b0;
        if (sel == `SAC_TRIG_SW) begin
            start = sw_go;
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (sel == 3'(i + 1)) begin
                    start = edge_w[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= prev_d;
        end
    end
endmodule : sac_trig

// >>> test/sac_afe_model.sv
// Stand-in for the analog core and input multiplexer: one level per
// channel, compared with the trial code within the same cycle.
// Assumes the bench changes channel levels only between conversions.
module sac_afe_model (
    input wire logic sys_clk,
    input sac_pkg::sac_afe_t afe,
    input wire logic [15:0][11:0] level,
    output logic comp_hi
);
    timeunit 1ns;
    timeprecision 1ns;
    logic junk_q = 1'b0;
    // An unpowered core gives no steady answer, so none is offered
    always @(posedge sys_clk) begin
        junk_q <= ~junk_q;
    end
    always_comb begin
        if (afe.powered) begin
            comp_hi = level[afe.chan] >= afe.trial;
        end else begin
            comp_hi = junk_q;
        end
    end
endmodule : sac_afe_model

// >>> test/test_sar_adc_control_12bit.sv
// Self-checking bench for the converter control block and its core.
// Assumes sac_regs.svh on the include path and a 10 MHz system clock.
`include "sac_regs.svh"
module test_sar_adc_control_12bit;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    sac_pkg::sac_av_req_t req = '0;
    logic [31:0] rdata;
    logic wreq;
    logic comp_hi;
    logic [5:0] tmr = 6'h00;
    logic stop = 1'b0;
    logic ack = 1'b0;
    sac_pkg::sac_afe_t afe;
    logic irq;
    logic [15:0][11:0] level = '0;
    logic [15:0] exp_q[$];
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 32'hC9AB;

    sac_adc_ctrl dut (.sys_clk(sys_clk), .rst(rst), .av_req(req),
        .av_readdata(rdata), .av_waitrequest(wreq), .comp_hi(comp_hi),
        .timer_match(tmr), .stop_mode(stop), .int_ack(ack), .afe(afe),
        .irq(irq));
    sac_afe_model core (.sys_clk(sys_clk), .afe(afe), .level(level),
        .comp_hi(comp_hi));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
    end

    task automatic fail(input string m);
        errors++;
        $display("wrong value at %0t: %s", $time, m);
    endtask : fail
    task automatic check_bit(input logic got, input logic e, input string m);
        check_count++;
        if (got !== e) begin
            fail(m);
        end
    endtask : check_bit
    task automatic check_read(input logic [31:0] got, input logic [15:0] e);
        check_count++;
        if ((got & {24'hFFFFFF, e[15:8]}) !== {24'h0, e[7:0] & e[15:8]}) begin
            fail("read data");
        end
    endtask : check_read
    task automatic report_and_stop;
        $display("checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.address <= idx << 2;
        req.read <= ~wr;
        req.write <= wr;
        req.writedata <= {24'h0, d};
        req.byteenable <= 4'hF;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail("bus hang");
        end
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [15:0] idx, input logic [7:0] v,
                      input logic [7:0] m);
        exp_q.push_back({m, v});
        bus(1'b0, idx, 8'h00);
    endtask : rd
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_irq
    task automatic pulse_tmr(input logic [5:0] t);
        @(posedge sys_clk);
        tmr <= t;
        @(posedge sys_clk);
        tmr <= 6'h00;
        repeat (3) @(posedge sys_clk);
    endtask : pulse_tmr

    // Software start, a dropped second start, then result and flags
    task automatic conv(input logic [1:0] d, input logic [3:0] ch);
        logic [11:0] v;
        logic al;
        logic rf;
        int t0;
        v = $random(seed);
        al = d[0];
        rf = v[0];
        level[ch] <= v;
        wr(`SAC_IDX_CTRL_HI, {5'h00, al, d});
        wr(`SAC_IDX_CTRL_LO, {2'b11, rf, 1'b0, ch});
        t0 = cyc;
        rd(`SAC_IDX_CTRL_LO, {2'b10, rf, 1'b0, ch}, 8'hFF);
        wr(`SAC_IDX_CTRL_LO, {2'b11, rf, 1'b0, ch});
        check_bit(afe.chan === ch, 1'b1, "chan");
        check_bit(afe.core_supply, ch == 4'hF, "core");
        check_bit(afe.ref_ext, rf, "ref");
        wait_irq(2000);
        check_bit(irq, 1'b1, "no irq");
        check_bit(cyc - t0 >= (58 << d) && cyc - t0 <= (58 << d) + 8,
                  1'b1, "conv time");
        rd(`SAC_IDX_RES_HI, al ? {4'h0, v[11:8]} : v[11:4], 8'hFF);
        rd(`SAC_IDX_RES_LO, al ? v[7:0] : {v[3:0], 4'h0}, 8'hFF);
        rd(`SAC_IDX_CTRL_LO, {2'b10, rf, 1'b1, ch}, 8'hFF);
        rd(`SAC_IDX_STATUS, 8'h03, 8'h03);
        wr(`SAC_IDX_CTRL_HI, {5'h10, al, d});
        rd(`SAC_IDX_CTRL_HI, {5'h10, al, d}, 8'hFF);
        if (d[0]) begin
            @(posedge sys_clk);
            ack <= 1'b1;
            @(posedge sys_clk);
            ack <= 1'b0;
        end else begin
            wr(`SAC_IDX_CTRL_HI, {5'h00, al, d});
        end
        rd(`SAC_IDX_CTRL_HI, {5'h00, al, d}, 8'hFF);
        wr(`SAC_IDX_STATUS, 8'h03);
        rd(`SAC_IDX_STATUS, 8'h00, 8'h03);
        check_bit(irq, 1'b0, "irq stuck");
    endtask : conv

    always @(posedge sys_clk) begin
        if (req.read === 1'b1 && wreq === 1'b0) begin
            if (exp_q.size() == 0) begin
                fail("stray read");
            end else begin
                check_read(rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        #3000000;
        fail("timeout");
        report_and_stop();
    end

    initial begin
        logic [5:0] sel;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`SAC_IDX_CTRL_LO, 8'h00, 8'hFF);
        rd(`SAC_IDX_CTRL_HI, 8'h00, 8'hFF);
        rd(`SAC_IDX_STATUS, 8'h00, 8'h03);
        rd(16'h1056, 8'h00, 8'hFF);
        wr(`SAC_IDX_RES_LO, 8'hFF);
        rd(`SAC_IDX_RES_LO, 8'h00, 8'hFF);
        wr(`SAC_IDX_MASK, 8'h01);
        rd(`SAC_IDX_MASK, 8'h01, 8'h03);
        // all four divider codes, bit 0 of the code also setting the alignment
        for (int d = 0; d < 4; d++) begin
            conv(d[1:0], d == 3 ? 4'hF : 4'($random(seed)));
        end
        for (int k = 1; k < 8; k++) begin
            sel = k < 7 ? 6'h01 << (k - 1) : 6'h00;
            wr(`SAC_IDX_CTRL_HI, {2'b00, k[2:0], 3'b011});
            wr(`SAC_IDX_CTRL_LO, 8'h83);
            pulse_tmr(~sel);
            check_bit(afe.sample, 1'b0, "wrong timer");
            if (k < 7) begin
                pulse_tmr(sel);
                wait_irq(2000);
                check_bit(irq, 1'b1, "timer start");
                wr(`SAC_IDX_STATUS, 8'h03);
            end
        end
        wr(`SAC_IDX_CTRL_LO, 8'h02);
        rd(`SAC_IDX_CTRL_LO, 8'h02, 8'hFF);
        wr(`SAC_IDX_CTRL_HI, 8'h03);
        // Interrupt flag is clear here, so a written one must not set it
        wr(`SAC_IDX_CTRL_HI, 8'h83);
        rd(`SAC_IDX_CTRL_HI, 8'h03, 8'hFF);
        wr(`SAC_IDX_CTRL_LO, 8'h82);
        // A start would show in the sampling phase two edges later
        repeat (3) @(posedge sys_clk);
        check_bit(afe.sample, 1'b0, "zero start");
        wr(`SAC_IDX_CTRL_LO, 8'hC2);
        wr(`SAC_IDX_CTRL_LO, 8'h02);
        wait_irq(600);
        check_bit(irq, 1'b0, "abort");
        wr(`SAC_IDX_CTRL_LO, 8'hC2);
        wait_irq(2000);
        rd(`SAC_IDX_CTRL_LO, 8'h92, 8'hFF);
        @(posedge sys_clk);
        stop <= 1'b1;
        rd(`SAC_IDX_CTRL_LO, 8'h82, 8'hFF);
        check_bit(afe.powered, 1'b0, "stop power");
        wr(`SAC_IDX_CTRL_LO, 8'hC2);
        repeat (3) @(posedge sys_clk);
        check_bit(afe.sample, 1'b0, "stop start");
        @(posedge sys_clk);
        stop <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check_bit(afe.powered, 1'b1, "wake power");
        report_and_stop();
    end
endmodule : test_sar_adc_control_12bit
